// ===== core/analog_input_defines.svh
// Register references, answer codes and timing counts of the analog input
// data register bank. Assumes a 250 MHz module clock.
`ifndef ANALOG_INPUT_DEFINES_SVH
`define ANALOG_INPUT_DEFINES_SVH

// Read functions and answer codes of the serial protocol.
`define FUNC_READ_HOLDING 8'h03
`define FUNC_READ_INPUT 8'h04
`define EXC_ILLEGAL_FUNC 8'h01
`define EXC_ILLEGAL_ADDR 8'h02
`define EXC_ILLEGAL_VALUE 8'h03
`define EXC_BUSY 8'h06

// Data register references: first and last channel.
`define REF_CHANNEL_FIRST 16'h9C71
`define REF_CHANNEL_LAST 16'h9C77
`define NUM_CHANNELS 7

// Code range: negative and positive full scale.
`define CODE_NEG_FULL 16'h0000
`define CODE_POS_FULL 16'hFFFF

// Timing, in their own units, and derived cycle counts.
`define CLOCK_MHZ 250
`define BUSY_TIME_MS 3000
`define CONV_PERIOD_FAST_US 40000
`define CONV_PERIOD_SLOW_US 50000
`define BUSY_CYCLES (`BUSY_TIME_MS * 1000 * `CLOCK_MHZ)
`define CONV_CYCLES_FAST (`CONV_PERIOD_FAST_US * `CLOCK_MHZ)
`define CONV_CYCLES_SLOW (`CONV_PERIOD_SLOW_US * `CLOCK_MHZ)

`endif

// ===== core/analog_input_pkg.sv
// Types shared by the analog input data register bank.
// Assumes the defines header is compiled alongside.
package analog_input_pkg;

	// One decoded read request from the frame parser.
	typedef struct packed {
		logic [7:0] func;
		logic [15:0] start;
		logic [15:0] count;
	} request_s;

	// One answer beat: a data word or an exception.
	typedef struct packed {
		logic [15:0] word;
		logic [7:0] exc_code;
		logic is_exc;
		logic last;
	} answer_s;

	// One converter result.
	typedef struct packed {
		logic [2:0] channel;
		logic [15:0] code;
		logic open_input;
		logic over_range;
	} conversion_s;

	// Setup image held in nonvolatile memory.
	typedef struct packed {
		logic [6:0] enable;
		logic slow_rate;
		logic [2:0] filter_shift;
	} setup_s;

	typedef enum logic {answer_idle, answer_stream} answer_state_e;
	typedef enum logic {seq_wait, seq_convert} seq_state_e;

endpackage

// ===== core/analog_input_data_registers.sv
// Seven-channel analog input data register bank with request server,
// conversion sequencer, digital filter and setup retention.
// Assumes frame parsing, CRC and the converter run on this same clock.
// Function
// R01 - Read-holding and read-input requests both return the data registers.
// R02 - Channels 0 to 6 sit at consecutive references 40049 to 40055.
// R03 - One request may read all seven registers in one answer.
// R04 - Codes are 16-bit unsigned, 0 at minus and 65535 at plus full scale.
// R05 - Codes in between map linearly onto the input span.
// R06 - Results refresh from a 16-bit converter at 25 or 20 per second.
// R07 - Host-disabled channels are skipped in the conversion sequence.
// R08 - Setups live in nonvolatile memory and survive reset.
// R09 - A programmable digital filter smooths each channel's results.
// R10 - Open input and over-range are indicated apart from valid readings.
// R11 - An unsupported register address is answered with exception 02.
// R12 - For 3 s after reset every request is answered with exception 06.
// R13 - Each data register updates whole, in one cycle, at conversion end.
`timescale 1ns/10ps
`include "analog_input_defines.svh"

module analog_input_data_registers import analog_input_pkg::*; #(
	parameter int unsigned BUSY_CYCLES = `BUSY_CYCLES,
	parameter int unsigned CONV_CYCLES_FAST = `CONV_CYCLES_FAST,
	parameter int unsigned CONV_CYCLES_SLOW = `CONV_CYCLES_SLOW
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic reset,
	// Decoded requests and answers.
	input wire logic req_valid,
	input wire request_s req,
	output logic req_ready_ff,
	output logic ans_valid_ff,
	output answer_s ans_ff,
	// Converter control and results.
	output logic conv_start_ff,
	output logic [2:0] conv_channel_ff,
	input wire logic conv_done,
	input wire conversion_s conv,
	// Setup writes and nonvolatile image.
	input wire logic setup_write,
	input wire setup_s setup_new,
	input wire setup_s nv_image,
	output logic nv_store_ff,
	output setup_s nv_store_data_ff,
	output setup_s setup_ff,
	// Fault indication and busy state.
	output logic [6:0] open_input_ff,
	output logic [6:0] over_range_ff,
	output logic busy_ff
);

	logic [6:0][15:0] value_ff;
	logic load_pending_ff;
	logic [31:0] busy_cnt_ff;
	logic [31:0] period_cnt_ff;
	logic tick_pending_ff;
	seq_state_e seq_ff;
	answer_state_e ans_state_ff;
	logic [2:0] ptr_ff;
	logic [15:0] remain_ff;
	logic req_take;
	logic [16:0] req_end;
	logic [2:0] nxt_channel;
	logic period_end;

	// Setup is restored from the nonvolatile image one cycle after reset,
	// so a reset never leaves stale or default setups in force.
	always_ff @(posedge clock) begin
		if (reset) begin
			load_pending_ff <= 1'b1;
			setup_ff <= '0;
			nv_store_ff <= 1'b0;
			nv_store_data_ff <= '0;
		end else begin
			load_pending_ff <= 1'b0;
			nv_store_ff <= 1'b0;
			if (load_pending_ff) begin
				setup_ff <= nv_image; // [R08]
			end else if (setup_write) begin
				setup_ff <= setup_new;
				nv_store_ff <= 1'b1; // [R08]
				nv_store_data_ff <= setup_new;
			end
		end
	end

	// Start-up busy window.
	always_ff @(posedge clock) begin
		if (reset) begin
			busy_cnt_ff <= '0;
			busy_ff <= 1'b1;
		end else if (busy_ff) begin
			busy_cnt_ff <= busy_cnt_ff + 32'h1;
			busy_ff <= (busy_cnt_ff + 32'h1) < BUSY_CYCLES; // [R12]
		end
	end

	// Conversion pacing timer; the rate select picks 25 or 20 per second.
	assign period_end = period_cnt_ff >=
		((setup_ff.slow_rate ? CONV_CYCLES_SLOW : CONV_CYCLES_FAST) - 1);
	always_ff @(posedge clock) begin
		if (reset) begin
			period_cnt_ff <= '0;
			tick_pending_ff <= 1'b0;
		end else begin
			period_cnt_ff <= period_end ? 32'h0 : period_cnt_ff + 32'h1;
			if (period_end) begin
				tick_pending_ff <= 1'b1; // [R06]
			end else if (conv_start_ff) begin
				tick_pending_ff <= 1'b0;
			end
		end
	end

	// Next enabled channel after the current one, wrapping round.
	always_comb begin
		logic found;
		logic [3:0] idx;
		found = 1'b0;
		idx = 4'h0;
		nxt_channel = conv_channel_ff;
		for (int i = 1; i <= `NUM_CHANNELS; i++) begin
			idx = 4'(conv_channel_ff) + 4'(i);
			if (idx >= 4'h7) begin
				idx = idx - 4'h7;
			end
			if (!found && setup_ff.enable[idx[2:0]]) begin
				found = 1'b1;
				nxt_channel = idx[2:0]; // [R07]
			end
		end
	end

	// Sequencer: one conversion per tick, only on enabled channels.
	always_ff @(posedge clock) begin
		if (reset) begin
			seq_ff <= seq_wait;
			conv_start_ff <= 1'b0;
			conv_channel_ff <= 3'h6;
		end else begin
			conv_start_ff <= 1'b0;
			unique case (seq_ff)
				seq_wait: begin
					if (tick_pending_ff && !conv_start_ff &&
						|setup_ff.enable && !load_pending_ff) begin
						conv_start_ff <= 1'b1;
						conv_channel_ff <= nxt_channel; // [R07]
						seq_ff <= seq_convert;
					end
				end
				seq_convert: begin
					if (conv_done) begin
						seq_ff <= seq_wait;
					end
				end
			endcase
		end
	end

	// Filter and store per channel. The whole word is written in one cycle,
	// so a read never mixes bytes of two conversions.
	for (genvar ch = 0; ch < `NUM_CHANNELS; ch++) begin : g_chan
		logic signed [17:0] diff;
		logic signed [17:0] step;
		logic [17:0] filtered;
		assign diff = 18'(conv.code) - 18'(value_ff[ch]);
		assign step = diff >>> setup_ff.filter_shift; // [R09]
		assign filtered = 18'(value_ff[ch]) + step;
		always_ff @(posedge clock) begin
			if (reset) begin
				value_ff[ch] <= `CODE_NEG_FULL;
				open_input_ff[ch] <= 1'b0;
				over_range_ff[ch] <= 1'b0;
			end else if (conv_done && conv.channel == 3'(ch)) begin
				open_input_ff[ch] <= conv.open_input; // [R10]
				over_range_ff[ch] <= conv.over_range; // [R10]
				if (conv.open_input || conv.over_range) begin
					value_ff[ch] <= `CODE_POS_FULL; // [R10]
				end else begin
					value_ff[ch] <= filtered[15:0]; // [R13] [R04] [R05]
				end
			end
		end
	end

	// Request decode: last reference covered by the request.
	assign req_take = req_valid && req_ready_ff;
	assign req_end = 17'(req.start) + 17'(req.count) - 17'h1;

	// Answer server: exception beats or a run of data words.
	always_ff @(posedge clock) begin
		if (reset) begin
			ans_state_ff <= answer_idle;
			req_ready_ff <= 1'b0;
			ans_valid_ff <= 1'b0;
			ans_ff <= '0;
			ptr_ff <= '0;
			remain_ff <= '0;
		end else begin
			ans_valid_ff <= 1'b0;
			unique case (ans_state_ff)
				answer_idle: begin
					req_ready_ff <= 1'b1;
					if (req_take) begin
						ans_valid_ff <= 1'b1;
						ans_ff <= '{word: 16'h0, exc_code: 8'h0,
							is_exc: 1'b1, last: 1'b1};
						if (busy_ff) begin
							ans_ff.exc_code <= `EXC_BUSY; // [R12]
						end else if (req.func != `FUNC_READ_HOLDING &&
							req.func != `FUNC_READ_INPUT) begin
							ans_ff.exc_code <= `EXC_ILLEGAL_FUNC;
						end else if (req.count == 16'h0) begin
							ans_ff.exc_code <= `EXC_ILLEGAL_VALUE;
						end else if (req.start < `REF_CHANNEL_FIRST ||
							req_end > 17'(`REF_CHANNEL_LAST)) begin
							ans_ff.exc_code <= `EXC_ILLEGAL_ADDR; // [R11]
						end else begin
							// Both read functions see the same words.
							ans_ff.is_exc <= 1'b0; // [R01]
							ans_ff.word <= value_ff[3'(req.start -
								`REF_CHANNEL_FIRST)]; // [R02]
							ans_ff.last <= req.count == 16'h1;
							ptr_ff <= 3'(req.start - `REF_CHANNEL_FIRST) +
								3'h1;
							remain_ff <= req.count - 16'h1;
							if (req.count != 16'h1) begin
								req_ready_ff <= 1'b0;
								ans_state_ff <= answer_stream; // [R03]
							end
						end
					end
				end
				answer_stream: begin
					ans_valid_ff <= 1'b1;
					ans_ff.word <= value_ff[ptr_ff]; // [R03]
					ans_ff.last <= remain_ff == 16'h1;
					ptr_ff <= ptr_ff + 3'h1;
					remain_ff <= remain_ff - 16'h1;
					if (remain_ff == 16'h1) begin
						req_ready_ff <= 1'b1;
						ans_state_ff <= answer_idle;
					end
				end
			endcase
		end
	end

	AST_BUSY_EXC: assert property (@(posedge clock) disable iff (reset) // [R12]
		req_take && busy_ff |=> ans_valid_ff && ans_ff.is_exc &&
		ans_ff.exc_code == 8'h06)
		else $error("Request during start-up not answered busy.");
	AST_NO_DATA_BUSY: assert property (@(posedge clock) // [R12]
		disable iff (reset)
		ans_valid_ff && !ans_ff.is_exc |-> !$past(busy_ff, 1))
		else $error("Data answered during start-up window.");
	AST_READ_FUNCS: assert property (@(posedge clock) // [R01]
		disable iff (reset)
		req_take && !busy_ff && req.func inside {8'h03, 8'h04} &&
		req.start == 16'h9C71 && req.count == 16'h1
		|=> ans_valid_ff && !ans_ff.is_exc && ans_ff.last &&
		ans_ff.word == $past(value_ff[0]))
		else $error("Read of channel 0 not answered with its value.");
	AST_BAD_ADDR: assert property (@(posedge clock) // [R11]
		disable iff (reset)
		req_take && !busy_ff && req.func == 8'h03 && req.count == 16'h1 &&
		(req.start == 16'h9C70 || req.start == 16'h9C78)
		|=> ans_valid_ff && ans_ff.is_exc && ans_ff.exc_code == 8'h02)
		else $error("Unsupported address not answered with code 02.");
	AST_FULL_BLOCK: assert property (@(posedge clock) // [R03]
		disable iff (reset)
		req_take && !busy_ff && req.func == 8'h04 &&
		req.start == 16'h9C71 && req.count == 16'h7
		|=> (ans_valid_ff && !ans_ff.last && !ans_ff.is_exc)[*6]
		##1 (ans_valid_ff && ans_ff.last && ans_ff.word == $past(value_ff[6])))
		else $error("Seven-register read not answered in seven beats.");
	AST_SKIP_DISABLED: assert property (@(posedge clock) // [R07]
		disable iff (reset)
		conv_start_ff |-> |($past(setup_ff.enable) & (7'h01 << conv_channel_ff)))
		else $error("Disabled channel was converted.");
	AST_ATOMIC: assert property (@(posedge clock) // [R13]
		disable iff (reset)
		$changed(value_ff) |-> $past(conv_done))
		else $error("Data register changed outside a conversion end.");
	AST_FAULT: assert property (@(posedge clock) // [R10]
		disable iff (reset)
		conv_done && conv.over_range && conv.channel == 3'h2
		|=> value_ff[2] == 16'hFFFF && over_range_ff[2])
		else $error("Over-range not indicated.");
	AST_FILTER_OFF: assert property (@(posedge clock) // [R09]
		disable iff (reset)
		conv_done && setup_ff.filter_shift == 3'h0 && !conv.open_input &&
		!conv.over_range && conv.channel == 3'h4
		|=> value_ff[4] == $past(conv.code))
		else $error("Unfiltered result not stored as converted.");
	AST_NV_RESTORE: assert property (@(posedge clock) // [R08]
		$fell(reset) |=> setup_ff == $past(nv_image))
		else $error("Setup not restored from nonvolatile image.");

endmodule

// ===== verification/converter_model.sv
// Converter stand-in for the analog input bank: answers each start pulse.
// Assumes the bank's clock and at most one conversion in flight.
`timescale 1ns/10ps

module converter_model import analog_input_pkg::*; #(
	parameter int DELAY = 5
) (
	// Clock and control from the bank.
	input wire logic clock,
	input wire logic start,
	input wire logic [2:0] channel,
	// Fault injection from the bench.
	input wire logic fault_open,
	input wire logic fault_over,
	// Result to the bank.
	output logic done = 1'b0,
	output conversion_s result = '0
);
	int count = 0;
	logic [2:0] chan_ff = 3'h0;

	// Idle result lines flip every cycle, so a late sample never matches.
	always @(posedge clock) begin
		done <= 1'b0;
		result <= ~result;
		if (start) begin
			count <= DELAY;
			chan_ff <= channel;
		end else if (count > 0) begin
			count <= count - 1;
		end
		if (!start && count == 1) begin
			done <= 1'b1;
			result <= '{chan_ff, {1'b0, chan_ff, 12'hA5C}, fault_open,
				fault_over};
		end
	end
endmodule

// ===== verification/tb_top.sv
// Self-checking bench for the analog input data register bank.
// Assumes shortened busy and conversion periods set below.
`timescale 1ns/10ps
`include "analog_input_defines.svh"

module tb_top import analog_input_pkg::*; ();
	logic clock = 1'b0;
	logic reset, req_valid, req_ready_ff, ans_valid_ff, conv_start_ff;
	logic conv_done, setup_write, nv_store_ff, busy_ff;
	logic fault_open, fault_over;
	logic [2:0] conv_channel_ff, ch;
	logic [6:0] open_input_ff, over_range_ff;
	request_s req;
	answer_s ans_ff, last_ans;
	conversion_s conv;
	setup_s setup_new, nv_store_data_ff, setup_ff;
	setup_s nv_mem = 11'h7F0;
	logic [15:0] words [16];
	int nbeats, gap, checked = 0, fail_count = 0;

	analog_input_data_registers #(.BUSY_CYCLES(50), .CONV_CYCLES_FAST(40),
		.CONV_CYCLES_SLOW(50)) analog_input_data_registers_i (
		.clock(clock), .reset(reset), .req_valid(req_valid), .req(req),
		.req_ready_ff(req_ready_ff), .ans_valid_ff(ans_valid_ff),
		.ans_ff(ans_ff), .conv_start_ff(conv_start_ff),
		.conv_channel_ff(conv_channel_ff), .conv_done(conv_done),
		.conv(conv), .setup_write(setup_write), .setup_new(setup_new),
		.nv_image(nv_mem), .nv_store_ff(nv_store_ff),
		.nv_store_data_ff(nv_store_data_ff), .setup_ff(setup_ff),
		.open_input_ff(open_input_ff), .over_range_ff(over_range_ff),
		.busy_ff(busy_ff));

	converter_model converter_model_i (.clock(clock),
		.start(conv_start_ff), .channel(conv_channel_ff),
		.fault_open(fault_open), .fault_over(fault_over),
		.done(conv_done), .result(conv));

	// Free-running 250 MHz clock.
	always #2 clock = ~clock;

	// Nonvolatile setup memory: keeps the last stored image across reset.
	always @(posedge clock) begin
		if (nv_store_ff === 1'b1)
			nv_mem <= nv_store_data_ff;
	end

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Offer one request, hold it until taken, then gather its beats.
	task automatic xfer(input logic [7:0] f, input logic [15:0] s,
		input logic [15:0] n);
		int i;
		nbeats = 0;
		@(posedge clock);
		req_valid <= 1'b1;
		req <= '{f, s, n};
		i = 0;
		@(negedge clock);
		while (req_ready_ff !== 1'b1 && i < 100) begin
			@(negedge clock);
			i++;
		end
		@(posedge clock);
		req_valid <= 1'b0;
		for (i = 0; i < 12; i++) begin
			@(negedge clock);
			if (ans_valid_ff === 1'b1) begin
				words[nbeats] = ans_ff.word;
				last_ans = ans_ff;
				nbeats++;
				if (ans_ff.last === 1'b1)
					break;
			end
		end
	endtask

	task automatic read_all(input logic [7:0] f, input logic bad);
		xfer(f, 16'h9C71, 16'h0007);
		cmp(16'(nbeats), 16'h0007);
		for (int c = 0; c < 7; c++)
			cmp(words[c], bad ? 16'hFFFF : {1'b0, 3'(c), 12'hA5C});
	endtask

	task automatic expect_exc(input logic [15:0] s, input logic [15:0] n,
		input logic [7:0] code);
		xfer(8'h03, s, n);
		cmp(16'(nbeats), 16'h0001);
		cmp({7'h00, last_ans.is_exc, last_ans.exc_code},
			{8'h01, code});
	endtask

	task automatic setw(input setup_s s);
		@(posedge clock);
		setup_write <= 1'b1;
		setup_new <= s;
		@(posedge clock);
		setup_write <= 1'b0;
		@(negedge clock);
		cmp({15'h0000, nv_store_ff}, 16'h0001);
		cmp({5'h00, nv_store_data_ff}, {5'h00, s});
		cmp({5'h00, setup_ff}, {5'h00, s});
	endtask

	// Cycles between two start pulses, and the channel of the second.
	task automatic start_gap();
		int i;
		i = 0;
		gap = 0;
		while (conv_start_ff !== 1'b1 && i < 200) begin
			@(negedge clock);
			i++;
		end
		@(negedge clock);
		while (conv_start_ff !== 1'b1 && gap < 200) begin
			@(negedge clock);
			gap++;
		end
		gap++;
		ch = conv_channel_ff;
	endtask

	task automatic final_report();
		$display("checks %0d failures %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Watchdog well beyond the few thousand cycles the tests need.
	initial begin
		repeat (20000) @(posedge clock);
		fail_count++;
		final_report();
	end

	// Main sequence.
	initial begin
		reset = 1'b1;
		req_valid = 1'b0;
		req = '0;
		setup_write = 1'b0;
		setup_new = '0;
		fault_open = 1'b0;
		fault_over = 1'b0;
		repeat (8) @(posedge clock);
		reset <= 1'b0;
		repeat (2) @(posedge clock);
		expect_exc(16'h9C71, 16'h0001, 8'h06);
		for (int i = 0; i < 100 && busy_ff !== 1'b0; i++)
			@(posedge clock);
		repeat (400) @(posedge clock);
		read_all(8'h03, 1'b0);
		read_all(8'h04, 1'b0);
		xfer(8'h04, 16'h9C77, 16'h0001);
		cmp(words[0], 16'h6A5C);
		xfer(8'h03, 16'h9C71, 16'h0001);
		cmp(words[0], 16'h0A5C);
		expect_exc(16'h9C70, 16'h0001, 8'h02);
		expect_exc(16'h9C77, 16'h0002, 8'h02);
		expect_exc(16'h9C78, 16'h0001, 8'h02);
		fault_open <= 1'b1;
		repeat (400) @(posedge clock);
		read_all(8'h03, 1'b1);
		cmp({2'h0, open_input_ff, over_range_ff}, 16'h3F80);
		fault_open <= 1'b0;
		fault_over <= 1'b1;
		repeat (400) @(posedge clock);
		cmp({2'h0, open_input_ff, over_range_ff}, 16'h007F);
		fault_over <= 1'b0;
		repeat (400) @(posedge clock);
		read_all(8'h03, 1'b0);
		setw('{7'h01, 1'b0, 3'h0});
		start_gap();
		start_gap();
		cmp(16'(gap), 16'h0028);
		cmp({13'h0, ch}, 16'h0000);
		setw('{7'h01, 1'b1, 3'h0});
		start_gap();
		start_gap();
		cmp(16'(gap), 16'h0032);
		// Mid-run reset: the stored slow-rate setup must come back.
		@(posedge clock);
		reset <= 1'b1;
		repeat (8) @(posedge clock);
		reset <= 1'b0;
		repeat (2) @(posedge clock);
		@(negedge clock);
		cmp({5'h00, setup_ff}, 16'h0018);
		expect_exc(16'h9C71, 16'h0001, 8'h06);
		final_report();
	end
endmodule
